// ### core/ccz_pkg.sv
// What this block does
// RL1 - Hold 32-bit control word; write command loads it, read command returns it
// RL2 - Write command from bitstream loads the word exactly like host write
// RL3 - Bit 29 clear: output, write and set-reset wake-up signals low in reconfig
// RL4 - Bit 29 set: wake-up signals follow leave-io-alone captured at reconfig start
// RL5 - Bit 28 set: user outputs hold previous value in access state, not tri-stated; the code holds only in transparent mode and tri-states otherwise
// RL6 - Array writes in transparent mode allowed only when bit 25 set
// RL7 - Bit 24 set: config logic takes block RAMs, user RAM access suspended; the code suspends only in transparent mode
// RL8 - Bit 23 set: config logic takes init bus, hard IP user access suspended; the code suspends only in transparent mode
// RL9 - Bit 19 picks boot address at next refresh: fabric bits or fixed pair
// RL10 - Bits 18:17 override finish command: 10 bypass, 11 pass-through, 0X none
// RL11 - Bits 7:6 pick pin speed: 00 slow, 01 medium, 1X fast
// RL12 - Bits 5:0 give master SPI clock divide ratio from oscillator
// RL13 - Reserved bits read zero and writes to them have no effect
package ccz_pkg;

    localparam logic [31:0] CCZ_RESET_VALUE      = 32'h0000_0000;
    // Writable bits: 29,28,25,24,23,19,18,17,7..0
    localparam logic [31:0] CCZ_WRITABLE_MASK    = 32'h338e_00ff;
    localparam int          CCZ_WAKEUP_SEL_BIT   = 29;
    localparam int          CCZ_LEAVE_IO_BIT     = 28;
    localparam int          CCZ_ARRAY_WRITE_BIT  = 25;
    localparam int          CCZ_BRAM_TAKE_BIT    = 24;
    localparam int          CCZ_HARD_IP_TAKE_BIT = 23;
    localparam int          CCZ_MULTIBOOT_BIT    = 19;
    localparam int          CCZ_FINISH_OVR_HI    = 18;
    localparam int          CCZ_FINISH_OVR_LO    = 17;
    localparam int          CCZ_SLEW_HI          = 7;
    localparam int          CCZ_SLEW_LO          = 6;
    localparam int          CCZ_SPI_DIV_HI       = 5;
    localparam int          CCZ_SPI_DIV_LO       = 0;
    localparam logic [23:0] CCZ_FIRST_BOOT_ADDR  = 24'h00_0000;
    localparam logic [23:0] CCZ_SECOND_BOOT_ADDR = 24'hff_ff00;

    typedef enum logic [1:0]
    {
        CCZ_SLEW_SLOW   = 2'h0,
        CCZ_SLEW_MEDIUM = 2'h1,
        CCZ_SLEW_FAST   = 2'h2
    } ccz_slew_t;

    typedef enum logic [1:0]
    {
        CCZ_FIN_NONE   = 2'h0,
        CCZ_FIN_BYPASS = 2'h2,
        CCZ_FIN_PASS   = 2'h3
    } ccz_finish_t;

    typedef struct packed
    {
        logic        transparent_array_write;
        logic        transparent_block_ram_takeover;
        logic        transparent_hard_ip_takeover;
        ccz_finish_t finish_override_select;
        ccz_slew_t   pin_slew;
        logic [5:0]  spi_clock_divide;
    } ccz_ctrl_t;

    typedef struct packed
    {
        logic global_output_enable;
        logic global_write_enable;
        logic global_set_reset_n;
    } ccz_wakeup_t;

endpackage

// ### core/ccz_config_control_zero.sv
`timescale 1ns/1ps
`default_nettype none
module ccz_config_control_zero
(
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rstn,
    // Command port from host and from bitstream engine
    input  wire logic                 host_write,
    input  wire logic                 host_read,
    input  wire logic [31:0]          host_wdata,
    input  wire logic                 stream_write,
    input  wire logic [31:0]          stream_wdata,
    output logic [31:0]               read_data,
    output logic                      read_valid,
    // Reconfiguration events and state
    input  wire logic                 reprogram_request_pin,
    input  wire logic                 refresh_command,
    input  wire logic                 reconfig_active,
    input  wire logic                 programming_access_state,
    input  wire logic                 transparent_mode,
    input  wire logic                 second_boot,
    input  wire logic [23:0]          fabric_boot_addr,
    input  wire ccz_pkg::ccz_wakeup_t user_wakeup,
    // Outputs to configuration engine
    output ccz_pkg::ccz_ctrl_t        ctrl,
    output ccz_pkg::ccz_wakeup_t      wakeup,
    output logic                      user_io_hold,
    output logic                      user_io_tristate,
    output logic                      array_write_allow,
    output logic                      user_bram_suspend,
    output logic                      user_hard_ip_suspend,
    output logic [23:0]               boot_address,
    output logic                      config_control_zero_read_unused
);
    import ccz_pkg::*;

    // ********************************
    // Register state
    // ********************************
    logic [31:0] config_control_zero;
    logic [31:0] next_config_control_zero;
    logic        leave_io_latched;
    logic        next_leave_io_latched;
    logic        wakeup_sel_latched;
    logic        next_wakeup_sel_latched;
    logic        multiboot_latched;
    logic        next_multiboot_latched;
    logic        prog_pin_q;
    logic        next_prog_pin_q;
    logic [31:0] next_read_data;
    logic        next_read_valid;
    logic        refresh_event;

    // Reprogram is a falling edge of the pin or a refresh command
    assign refresh_event = (prog_pin_q & ~reprogram_request_pin)
                         | refresh_command;

    always_comb
    begin
        next_config_control_zero = config_control_zero;
        // RL2 stream write
        // Host wins if both land in one cycle; the stream word is then dropped
        if (stream_write)
            next_config_control_zero = stream_wdata & CCZ_WRITABLE_MASK;
        // RL1 host write, RL13 mask
        if (host_write)
            next_config_control_zero = host_wdata & CCZ_WRITABLE_MASK;
        next_read_valid = host_read;
        // RL1 read back
        next_read_data  = host_read ? config_control_zero : read_data;
        next_prog_pin_q = reprogram_request_pin;
        next_leave_io_latched   = leave_io_latched;
        next_wakeup_sel_latched = wakeup_sel_latched;
        next_multiboot_latched  = multiboot_latched;
        // RL4 capture settings at the event
        if (refresh_event)
        begin
            next_leave_io_latched   = config_control_zero[CCZ_LEAVE_IO_BIT];
            next_wakeup_sel_latched = config_control_zero[CCZ_WAKEUP_SEL_BIT];
            next_multiboot_latched  = config_control_zero[CCZ_MULTIBOOT_BIT];
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            config_control_zero <= CCZ_RESET_VALUE;
            read_data           <= 32'h0000_0000;
            read_valid          <= 1'b0;
            prog_pin_q          <= 1'b1;
            leave_io_latched    <= 1'b0;
            wakeup_sel_latched  <= 1'b0;
            multiboot_latched   <= 1'b0;
        end
        else
        begin
            config_control_zero <= next_config_control_zero;
            read_data           <= next_read_data;
            read_valid          <= next_read_valid;
            prog_pin_q          <= next_prog_pin_q;
            leave_io_latched    <= next_leave_io_latched;
            wakeup_sel_latched  <= next_wakeup_sel_latched;
            multiboot_latched   <= next_multiboot_latched;
        end
    end

    // ********************************
    // Decoded controls
    // ********************************
    always_comb
    begin
        ctrl.transparent_array_write =
            config_control_zero[CCZ_ARRAY_WRITE_BIT];
        ctrl.transparent_block_ram_takeover =
            config_control_zero[CCZ_BRAM_TAKE_BIT];
        ctrl.transparent_hard_ip_takeover =
            config_control_zero[CCZ_HARD_IP_TAKE_BIT];
        // RL10 finish override, 0X means none
        if (config_control_zero[CCZ_FINISH_OVR_HI])
            ctrl.finish_override_select =
                config_control_zero[CCZ_FINISH_OVR_LO] ? CCZ_FIN_PASS
                                                       : CCZ_FIN_BYPASS;
        else
            ctrl.finish_override_select = CCZ_FIN_NONE;
        // RL11 both 1X codes are fast
        if (config_control_zero[CCZ_SLEW_HI])
            ctrl.pin_slew = CCZ_SLEW_FAST;
        else if (config_control_zero[CCZ_SLEW_LO])
            ctrl.pin_slew = CCZ_SLEW_MEDIUM;
        else
            ctrl.pin_slew = CCZ_SLEW_SLOW;
        // RL12 divide ratio
        ctrl.spi_clock_divide =
            config_control_zero[CCZ_SPI_DIV_HI:CCZ_SPI_DIV_LO];
    end

    // ********************************
    // Reconfiguration behaviour
    // ********************************
    always_comb
    begin
        wakeup = user_wakeup;
        if (reconfig_active)
        begin
            // RL3 wake-up forced low
            if (!wakeup_sel_latched || !leave_io_latched)
                wakeup = '0;
            // RL4 leave-io set keeps user wake-up levels
            else
                wakeup = user_wakeup;
        end
    end

    // RL5 hold outputs in access state
    assign user_io_hold     = programming_access_state & transparent_mode
                            & leave_io_latched;
    assign user_io_tristate = programming_access_state & ~user_io_hold;
    // RL6 array write gate
    assign array_write_allow = ~transparent_mode
                             | config_control_zero[CCZ_ARRAY_WRITE_BIT];
    // RL7 block RAM takeover
    assign user_bram_suspend = transparent_mode
                             & config_control_zero[CCZ_BRAM_TAKE_BIT];
    // RL8 hard IP takeover
    assign user_hard_ip_suspend = transparent_mode
                                & config_control_zero[CCZ_HARD_IP_TAKE_BIT];
    // RL9 boot address from setting taken at refresh
    assign boot_address = multiboot_latched ? fabric_boot_addr
                        : (second_boot ? CCZ_SECOND_BOOT_ADDR
                                       : CCZ_FIRST_BOOT_ADDR);
    assign config_control_zero_read_unused = 1'b0;

endmodule
`default_nettype wire

// ### verif/ccz_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// *
// Command host
// *
module ccz_host_model
(
    // Clock
    input  wire logic   clk,
    // Command pulses and words
    output logic        host_write,
    output logic        host_read,
    output logic [31:0] host_wdata,
    output logic        stream_write,
    output logic [31:0] stream_wdata
);
    initial {host_write, host_read, stream_write, host_wdata, stream_wdata} = '0;
    // Words flip after release so stale data never passes
    task automatic cmd(input logic [2:0] k, input logic [31:0] h, s);
        @(negedge clk);
        {host_write, host_read, stream_write} = k;
        {host_wdata, stream_wdata} = {h, s};
        @(negedge clk);
        {host_write, host_read, stream_write} = 3'h0;
        {host_wdata, stream_wdata} = {~h, ~s};
    endtask
endmodule
`default_nettype wire

// ### verif/ccz_config_control_zero_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// *
// Checks
// *
module ccz_chk
    import ccz_pkg::*;
(
    // Watched ports
    input wire logic               clk,
    input wire logic               rstn,
    input wire logic               host_write,
    input wire logic               host_read,
    input wire logic [31:0]        host_wdata,
    input wire logic               stream_write,
    input wire logic [31:0]        stream_wdata,
    input wire logic [31:0]        read_data,
    input wire logic               read_valid,
    input wire ccz_pkg::ccz_ctrl_t ctrl
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    rd_answer_a: assert property (host_read |=> read_valid)
        else $error("read not answered");
    rd_quiet_a: assert property (!host_read |=> !read_valid)
        else $error("stray read answer");
    wr_rd_a: assert property (host_write
        ##1 !(host_write || stream_write) ##1 host_read
        |=> read_data == ($past(host_wdata, 3) & CCZ_WRITABLE_MASK))
        else $error("readback");
    rsv_zero_a: assert property (read_valid |->
        (read_data & ~CCZ_WRITABLE_MASK) == 32'h0) else $error("reserved");
    host_load_a: assert property (host_write |=>
        ctrl.spi_clock_divide == $past(host_wdata[5:0])) else $error("load");
    bits_load_a: assert property (stream_write && !host_write |=>
        ctrl.spi_clock_divide == $past(stream_wdata[5:0])) else $error("bits");
    slew_fast_a: assert property (host_write && host_wdata[7] |=>
        ctrl.pin_slew == CCZ_SLEW_FAST) else $error("slew not fast");
    fin_none_a: assert property (host_write && !host_wdata[18] |=>
        ctrl.finish_override_select == CCZ_FIN_NONE) else $error("override");
endmodule
bind ccz_config_control_zero ccz_chk ccz_chk_i (.clk, .rstn, .host_write,
    .host_read, .host_wdata, .stream_write, .stream_wdata, .read_data,
    .read_valid, .ctrl);
`default_nettype wire

// ### verif/ccz_config_control_zero_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// *
// Bench
// *
module ccz_config_control_zero_tb_top;
    import ccz_pkg::*;
    logic clk = 1'b0, rstn = 1'b0, rf = 1'b0, rc = 1'b0, pa = 1'b0;
    logic tm = 1'b0, sb = 1'b0, hw, hr, sw, rv, ho, ts, aw, bs, ip;
    logic [23:0] ba, fa = 24'h0;
    logic [2:0]  uw = 3'h5;
    logic [31:0] hd, sd, rdd, a = 32'h0, sh = 32'h0, q[$];
    logic [31:0] kt = 32'h4156_4156;
    ccz_ctrl_t ct;
    ccz_wakeup_t wk;
    int failures = 0, checked = 0;
    initial forever #10 clk = ~clk;
    ccz_host_model ccz_host_model_i (.clk, .host_write(hw), .host_read(hr),
        .host_wdata(hd), .stream_write(sw), .stream_wdata(sd));
    ccz_config_control_zero ccz_config_control_zero_i (.clk, .rstn,
        .host_write(hw), .host_read(hr), .host_wdata(hd),
        .stream_write(sw), .stream_wdata(sd), .read_data(rdd),
        .read_valid(rv), .reprogram_request_pin(1'b1),
        .refresh_command(rf), .reconfig_active(rc),
        .programming_access_state(pa), .transparent_mode(tm),
        .second_boot(sb), .fabric_boot_addr(fa), .user_wakeup(uw),
        .ctrl(ct), .wakeup(wk), .user_io_hold(ho), .user_io_tristate(ts),
        .array_write_allow(aw), .user_bram_suspend(bs),
        .user_hard_ip_suspend(ip), .boot_address(ba),
        .config_control_zero_read_unused());
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) failures++;
        if (g !== e) $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    endtask
    task automatic close_out;
        $display("failures=%0d checked=%0d", failures, checked);
        if (failures == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Kind 1 stream only, 5 both (host wins), 6 write with read (old value)
    task automatic wr(input logic [31:0] d, input logic [2:0] k = 3'h4);
        if (k[1]) q.push_back(sh);
        sh = (k == 3'h1 ? ~d : d) & CCZ_WRITABLE_MASK;
        ccz_host_model_i.cmd(k, d, ~d);
    endtask
    task automatic rd;
        q.push_back(sh);
        ccz_host_model_i.cmd(3'h2, a, a);
    endtask
    task automatic refr;
        @(negedge clk) rf = 1'b1;
        @(negedge clk) rf = 1'b0;
        @(negedge clk);
    endtask
    always @(posedge clk)
        if (rv === 1'b1)
            cmp(rdd, q.pop_front());
    initial
    begin
        #20000;
        failures++;
        close_out;
    end
    initial
    begin
        void'($urandom(58758));
        repeat (4) @(posedge clk);
        @(negedge clk) rstn = 1'b1;
        rd;
        for (int i = 0; i < 8; i++)
        begin
            a = $urandom;
            wr(a, kt[4*i +: 3]);
            rd;
        end
        for (int i = 0; i < 4; i++)
        begin
            wr({13'h0, i[1:0], 17'h0} | {24'h0, i[1:0], 6'h0});
            cmp(ct.pin_slew, i[1] ? 2'h2 : i[1:0]);
            cmp(ct.finish_override_select, i[1] ? i[1:0] : 2'h0);
        end
        rc = 1'b1;
        wr(32'h0);
        refr;
        cmp(wk, 3'h0);
        wr(32'h3000_0000);
        pa = 1'b1;
        tm = 1'b1;
        refr;
        cmp(wk, uw);
        cmp({ho, ts}, 2'h2);
        wr(32'h0380_0000);
        cmp({aw, bs, ip}, 3'h7);
        sb = 1'b1;
        wr(32'h0);
        refr;
        cmp({aw, ba}, {1'b0, CCZ_SECOND_BOOT_ADDR});
        fa = 24'($urandom);
        wr(32'h0008_0000);
        refr;
        cmp(ba, fa);
        sb = 1'b0;
        wr(32'h0);
        refr;
        cmp(ba, CCZ_FIRST_BOOT_ADDR);
        rd;
        repeat (4) @(negedge clk);
        close_out;
    end
endmodule
`default_nettype wire
